// >>> dbcsp_pkg.sv
package dbcsp_pkg;
  // ==========================================================
  // Widths
  localparam int DATA_W = 36;
  localparam int LANE_W = 9;
  localparam int BW_W = 4;
  localparam int X18_LANES = 2;
  localparam int ADDR_W = 19;
  localparam int BURST_LEN = 4;
  localparam int BURST_W = DATA_W * BURST_LEN;
  localparam int BURST_BW_W = BW_W * BURST_LEN;
  localparam int IDX_W = ADDR_W + 2;
  localparam int MEM_DEPTH = 1 << IDX_W;
  localparam logic [DATA_W-1:0] X18_MASK = 36'h0_0003_FFFF;
  localparam logic [DATA_W-1:0] DATA_RST = 36'h0_0000_0000;

  // ==========================================================
  // Latencies in half cycles of the link clock, lock time in full link cycles
  localparam int RL_DLL_HALF = 5;
  localparam int RL_BYPASS_HALF = 2;
  localparam int WL_HALF = 2;
  localparam int DLL_LOCK_CYCLES = 2048;

  // ==========================================================
  // Link clock divider
  localparam int BYPASS_MAX_MHZ = 167;
  localparam int SYS_PERIOD_NS = 10;
  localparam int K_PERIOD_NS = 120;
  localparam int BYPASS_MIN_NS = (1000 + BYPASS_MAX_MHZ - 1) / BYPASS_MAX_MHZ;
  localparam int K_EFF_NS =
    (K_PERIOD_NS > BYPASS_MIN_NS) ? K_PERIOD_NS : BYPASS_MIN_NS;
  localparam int K_PERIOD_CYCLES =
    (K_EFF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int K_HALF_CYCLES = K_PERIOD_CYCLES / 2;
  localparam int K_QTR_CYCLES = K_HALF_CYCLES / 2;
  localparam int PH_W = 4;

  // ==========================================================
  // Reset values
  localparam logic K_RST = 1'b0;
  localparam logic LOAD_N_RST = 1'b1;
  localparam logic RNW_RST = 1'b1;
  localparam logic [BW_W-1:0] BW_N_RST = 4'hF;
  localparam logic DLL_OFF_N_RST = 1'b1;
  localparam logic ECHO_RST = 1'b0;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_ARM = 3'b001,
    H_CMD = 3'b010,
    H_WR = 3'b011,
    H_RD = 3'b100
  } dbcsp_hstate_type;
endpackage : dbcsp_pkg

// >>> dbcsp_if.sv
`timescale 1ns/1ps
interface dbcsp_if;
  import dbcsp_pkg::*;

  logic k;
  logic k_n;
  logic load_n;
  logic read_not_write;
  logic [ADDR_W-1:0] sync_address;
  logic [BW_W-1:0] byte_write_n;
  logic dll_off_n;
  logic echo_clock;
  logic echo_clock_n;
  logic read_valid;
  logic [DATA_W-1:0] dq_sram_out;
  logic dq_sram_oe;
  logic [DATA_W-1:0] dq_ctrl_out;
  logic dq_ctrl_oe;
  logic [DATA_W-1:0] data_bus;

  // ==========================================================
  // Shared bus level; undriven reads as zero
  assign data_bus = dq_sram_oe ? dq_sram_out :
                    dq_ctrl_oe ? dq_ctrl_out : {DATA_W{1'b0}};

  modport sram (
    input k, k_n, load_n, read_not_write, sync_address,
    input byte_write_n, dll_off_n, data_bus,
    output echo_clock, echo_clock_n, read_valid, dq_sram_out, dq_sram_oe
  );

  modport ctrl (
    output k, k_n, load_n, read_not_write, sync_address,
    output byte_write_n, dll_off_n, dq_ctrl_out, dq_ctrl_oe,
    input echo_clock, echo_clock_n, read_valid, data_bus
  );
endinterface : dbcsp_if

// >>> dbcsp_sync.sv
`timescale 1ns/1ps
module dbcsp_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // ==========================================================
  // Two stages; first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : dbcsp_sync

// >>> dbcsp_sram.sv
`timescale 1ns/1ps
// ============================================================
// Behaviour
// - Address and controls taken on true rising edge
// - Write data taken on both rising edges
// - Controller drives complementary clock opposite true
// - Echo clocks toggle always, even when idle
// - Read data launched with echo clock edges
// - Low DLL control bypasses and clears lock
// - High DLL control locks after lock time
// - Bypass gives one-cycle latency, limited frequency
// - Valid indicator moves with echo clock edges
// - Address ignored without a load
// - Bus driven only during an active read
// - Narrow configuration uses lower eighteen lines only
// - Load low starts read or write by direction
// - Controller loads with address and direction valid
// - Byte lanes stored only with enable low
// - Byte enables sampled with their data word
// - DLL read data starts two-and-half cycles later
// - Fixed burst of four, not cut short
// - Controller gives write data one cycle later
// - Valid leads first word, drops before last
module dbcsp_sram #(
  parameter bit X36_CFG = 1'b1
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  dbcsp_if.sram LINK,
  output logic DLL_LOCKED,
  output logic DLL_BYPASSED
);
  import dbcsp_pkg::*;

  localparam int SW = 5 + ADDR_W + BW_W + DATA_W;
  localparam int CMD_W = ADDR_W + 2;
  localparam int DLY_LEN = RL_DLL_HALF;
  localparam logic [11:0] LOCK_LAST = 12'(DLL_LOCK_CYCLES - 1);

  // ==========================================================
  // Pin synchronisers
  logic [SW-1:0] pins_raw;
  logic [SW-1:0] pins_syn;
  logic k_s;
  logic kn_inv_s;
  logic ld_n_s;
  logic rnw_s;
  logic dll_byp_s;
  logic [ADDR_W-1:0] addr_s;
  logic [BW_W-1:0] bw_n_s;
  logic [DATA_W-1:0] dq_s;

  // The k_n and dll_off_n pins enter inverted, so their reset value matches idle
  assign pins_raw = {LINK.k, ~LINK.k_n, LINK.load_n, LINK.read_not_write,
                     ~LINK.dll_off_n, LINK.sync_address,
                     LINK.byte_write_n, LINK.data_bus};

  dbcsp_sync #(.W(SW)) u_sync (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .d(pins_raw),
    .q(pins_syn)
  );

  assign {k_s, kn_inv_s, ld_n_s, rnw_s, dll_byp_s, addr_s, bw_n_s, dq_s} =
    pins_syn;

  // ==========================================================
  // Clock edges
  logic k_d_reg;
  logic kn_d_reg;
  logic k_rise;
  logic kn_rise;
  logic ev;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      k_d_reg <= 1'b0;
      kn_d_reg <= 1'b1;
    end else begin
      k_d_reg <= k_s;
      kn_d_reg <= ~kn_inv_s;
    end
  end

  assign k_rise = k_s & ~k_d_reg;
  // Only rising edges of each phase count; no falling-edge logic
  assign kn_rise = ~kn_inv_s & ~kn_d_reg;
  assign ev = k_rise | kn_rise;

  // ==========================================================
  // Storage
  logic [DATA_W-1:0] mem [0:MEM_DEPTH-1];

  function automatic logic [IDX_W-1:0] mem_idx(
    input logic [ADDR_W-1:0] base,
    input logic [1:0] beat
  );
    logic top;
    // Top address bit only exists in the narrow configuration
    top = X36_CFG ? 1'b0 : base[ADDR_W-1];
    return {top, base[ADDR_W-2:0], beat};
  endfunction : mem_idx

  function automatic logic [DATA_W-1:0] rd_word(
    input logic [IDX_W-1:0] idx
  );
    return X36_CFG ? mem[idx] : (mem[idx] & X18_MASK);
  endfunction : rd_word

  // ==========================================================
  // Command capture and delay line
  logic cmd_take;
  logic gap_reg;
  logic [CMD_W-1:0] cmd_line_reg [0:DLY_LEN-1];
  logic [CMD_W-1:0] rd_tap;
  logic [CMD_W-1:0] pre_tap;
  logic [CMD_W-1:0] wr_tap;
  logic rd_go;
  logic rd_pre;
  logic wr_go;

  // Second load inside a burst is dropped; bursts run to the end
  assign cmd_take = k_rise & ~ld_n_s & ~gap_reg;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      gap_reg <= 1'b0;
    end else if (cmd_take) begin
      gap_reg <= 1'b1;
    end else if (k_rise) begin
      gap_reg <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < DLY_LEN; i++) begin
        cmd_line_reg[i] <= {CMD_W{1'b0}};
      end
    end else if (ev) begin
      if (cmd_take) begin
        cmd_line_reg[0] <= {1'b1, rnw_s, addr_s};
      end else begin
        cmd_line_reg[0] <= {CMD_W{1'b0}};
      end
      for (int i = 1; i < DLY_LEN; i++) begin
        cmd_line_reg[i] <= cmd_line_reg[i-1];
      end
    end
  end

  assign rd_tap = !dll_byp_s ? cmd_line_reg[RL_DLL_HALF-1] :
                  cmd_line_reg[RL_BYPASS_HALF-1];
  assign pre_tap = !dll_byp_s ? cmd_line_reg[RL_DLL_HALF-2] :
                   cmd_line_reg[RL_BYPASS_HALF-2];
  assign wr_tap = cmd_line_reg[WL_HALF-1];
  assign rd_go = ev & rd_tap[CMD_W-1] & rd_tap[CMD_W-2];
  assign rd_pre = ev & pre_tap[CMD_W-1] & pre_tap[CMD_W-2];
  assign wr_go = ev & wr_tap[CMD_W-1] & ~wr_tap[CMD_W-2];

  // ==========================================================
  // Delay-locked loop
  logic [11:0] lock_cnt_reg;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lock_cnt_reg <= 12'h000;
      DLL_LOCKED <= 1'b0;
      DLL_BYPASSED <= 1'b0;
    end else begin
      DLL_BYPASSED <= dll_byp_s;
      if (dll_byp_s) begin
        lock_cnt_reg <= 12'h000;
        DLL_LOCKED <= 1'b0;
      end else if (k_rise && !DLL_LOCKED) begin
        if (lock_cnt_reg == LOCK_LAST) begin
          DLL_LOCKED <= 1'b1;
        end else begin
          lock_cnt_reg <= lock_cnt_reg + 12'h001;
        end
      end
    end
  end

  // ==========================================================
  // Echo clocks, free running from the input clocks
  logic echo_reg;
  logic echo_n_reg;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      echo_reg <= ECHO_RST;
      echo_n_reg <= ~ECHO_RST;
    end else if (k_rise) begin
      echo_reg <= 1'b1;
      echo_n_reg <= 1'b0;
    end else if (kn_rise) begin
      echo_reg <= 1'b0;
      echo_n_reg <= 1'b1;
    end
  end

  // ==========================================================
  // Write burst
  logic wr_on_reg;
  logic [1:0] wr_beat_reg;
  logic [1:0] wr_nbeat;
  logic [ADDR_W-1:0] wr_addr_reg;
  logic wr_now;
  logic [IDX_W-1:0] wr_idx;

  assign wr_nbeat = wr_beat_reg + 2'h1;
  assign wr_now = ev & (wr_go | (wr_on_reg & (wr_beat_reg != 2'h3)));
  assign wr_idx = wr_go ? mem_idx(wr_tap[ADDR_W-1:0], 2'h0) :
                  mem_idx(wr_addr_reg, wr_nbeat);

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_on_reg <= 1'b0;
      wr_beat_reg <= 2'h0;
      wr_addr_reg <= {ADDR_W{1'b0}};
    end else if (ev) begin
      if (wr_go) begin
        wr_on_reg <= 1'b1;
        wr_beat_reg <= 2'h0;
        wr_addr_reg <= wr_tap[ADDR_W-1:0];
      end else if (wr_on_reg && wr_beat_reg != 2'h3) begin
        wr_beat_reg <= wr_nbeat;
      end else begin
        wr_on_reg <= 1'b0;
      end
    end
  end

  // Enables come from the same sample as the data word
  always_ff @(posedge SYS_CLK) begin
    if (wr_now) begin
      for (int l = 0; l < BW_W; l++) begin
        if (!bw_n_s[l] && (X36_CFG || l < X18_LANES)) begin
          mem[wr_idx][l*LANE_W +: LANE_W] <= dq_s[l*LANE_W +: LANE_W];
        end
      end
    end
  end

  // ==========================================================
  // Read burst and output drive
  logic rd_on_reg;
  logic [1:0] rd_beat_reg;
  logic [1:0] rd_nbeat;
  logic [ADDR_W-1:0] rd_addr_reg;
  logic [DATA_W-1:0] dq_out_reg;
  logic dq_oe_reg;
  logic valid_reg;

  assign rd_nbeat = rd_beat_reg + 2'h1;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_on_reg <= 1'b0;
      rd_beat_reg <= 2'h0;
      rd_addr_reg <= {ADDR_W{1'b0}};
      dq_out_reg <= DATA_RST;
      dq_oe_reg <= 1'b0;
    end else if (ev) begin
      if (rd_go) begin
        rd_on_reg <= 1'b1;
        rd_beat_reg <= 2'h0;
        rd_addr_reg <= rd_tap[ADDR_W-1:0];
        dq_oe_reg <= 1'b1;
        dq_out_reg <= rd_word(mem_idx(rd_tap[ADDR_W-1:0], 2'h0));
      end else if (rd_on_reg && rd_beat_reg != 2'h3) begin
        rd_beat_reg <= rd_nbeat;
        dq_out_reg <= rd_word(mem_idx(rd_addr_reg, rd_nbeat));
      end else begin
        rd_on_reg <= 1'b0;
        dq_oe_reg <= 1'b0;
      end
    end
  end

  // Valid leads each burst by one phase, so it never marks beat 3
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      valid_reg <= 1'b0;
    end else if (ev) begin
      if (rd_pre) begin
        valid_reg <= 1'b1;
      end else if (rd_on_reg && rd_beat_reg == 2'h1) begin
        valid_reg <= 1'b0;
      end
    end
  end

  assign LINK.echo_clock = echo_reg;
  assign LINK.echo_clock_n = echo_n_reg;
  assign LINK.read_valid = valid_reg;
  assign LINK.dq_sram_out = dq_out_reg;
  assign LINK.dq_sram_oe = dq_oe_reg;
endmodule : dbcsp_sram

// >>> dbcsp_ctrl.sv
`timescale 1ns/1ps
module dbcsp_ctrl (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  dbcsp_if.ctrl LINK,
  input wire logic CMD_VALID,
  input wire logic CMD_WRITE,
  input wire logic [dbcsp_pkg::ADDR_W-1:0] CMD_ADDR,
  input wire logic [dbcsp_pkg::BURST_W-1:0] CMD_WDATA,
  input wire logic [dbcsp_pkg::BURST_BW_W-1:0] CMD_BW_N,
  input wire logic DLL_OFF_N,
  output logic CMD_READY,
  output logic WR_DONE,
  output logic RD_DONE,
  output logic [dbcsp_pkg::BURST_W-1:0] RD_DATA
);
  import dbcsp_pkg::*;

  localparam logic [PH_W-1:0] PH_LAST = PH_W'(K_PERIOD_CYCLES - 1);
  localparam logic [PH_W-1:0] PH_FALL = PH_W'(K_HALF_CYCLES - 1);
  localparam logic [PH_W-1:0] PH_D0 = PH_W'(K_QTR_CYCLES - 1);
  localparam logic [PH_W-1:0] PH_D1 = PH_W'(K_HALF_CYCLES + K_QTR_CYCLES - 1);

  // ==========================================================
  // Link clock divider
  logic [PH_W-1:0] ph_reg;
  logic k_reg;
  logic kn_reg;
  logic fall_tick;
  logic data_tick;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ph_reg <= {PH_W{1'b0}};
      k_reg <= K_RST;
      kn_reg <= ~K_RST;
    end else if (ph_reg == PH_LAST) begin
      ph_reg <= {PH_W{1'b0}};
      k_reg <= 1'b1;
      kn_reg <= 1'b0;
    end else begin
      ph_reg <= ph_reg + {{(PH_W-1){1'b0}}, 1'b1};
      if (ph_reg == PH_FALL) begin
        k_reg <= 1'b0;
        kn_reg <= 1'b1;
      end
    end
  end

  // Commands change on the falling edge, data mid-phase, clear of the edges that sample them
  assign fall_tick = (ph_reg == PH_FALL);
  assign data_tick = (ph_reg == PH_D0) || (ph_reg == PH_D1);

  // ==========================================================
  // Read capture on echo clock edges
  logic [1:0] echo_syn;
  logic [DATA_W-1:0] dq_syn;
  logic echo_d_reg;
  logic valid_d_reg;
  logic echo_edge;
  logic [2:0] cap_cnt_reg;
  logic cap_last;

  dbcsp_sync #(.W(DATA_W + 2)) u_sync (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .d({LINK.echo_clock, LINK.read_valid, LINK.data_bus}),
    .q({echo_syn, dq_syn})
  );

  assign echo_edge = echo_syn[1] ^ echo_d_reg;
  assign cap_last = echo_edge && (cap_cnt_reg == 3'h1);

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      echo_d_reg <= ECHO_RST;
      valid_d_reg <= 1'b0;
      cap_cnt_reg <= 3'h0;
      RD_DATA <= {BURST_W{1'b0}};
    end else begin
      echo_d_reg <= echo_syn[1];
      if (echo_edge) begin
        valid_d_reg <= echo_syn[0];
        if (cap_cnt_reg != 3'h0) begin
          RD_DATA[(3'h4 - cap_cnt_reg)*DATA_W +: DATA_W] <= dq_syn;
          cap_cnt_reg <= cap_cnt_reg - 3'h1;
        end
        if (echo_syn[0] && !valid_d_reg) begin
          cap_cnt_reg <= 3'(BURST_LEN);
        end
      end
    end
  end

  // ==========================================================
  // Command sequencer
  dbcsp_hstate_type state_reg;
  logic [2:0] beat_reg;
  logic req_write_reg;
  logic [ADDR_W-1:0] req_addr_reg;
  logic [BURST_W-1:0] req_data_reg;
  logic [BURST_BW_W-1:0] req_bw_reg;
  logic ld_n_reg;
  logic rnw_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [BW_W-1:0] bw_n_reg;
  logic [DATA_W-1:0] dq_reg;
  logic oe_reg;
  logic dll_reg;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      dll_reg <= DLL_OFF_N_RST;
    end else begin
      dll_reg <= DLL_OFF_N;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= H_IDLE;
      beat_reg <= 3'h0;
      req_write_reg <= 1'b0;
      req_addr_reg <= {ADDR_W{1'b0}};
      req_data_reg <= {BURST_W{1'b0}};
      req_bw_reg <= {BURST_BW_W{1'b1}};
      ld_n_reg <= LOAD_N_RST;
      rnw_reg <= RNW_RST;
      addr_reg <= {ADDR_W{1'b0}};
      bw_n_reg <= BW_N_RST;
      dq_reg <= DATA_RST;
      oe_reg <= 1'b0;
      CMD_READY <= 1'b1;
      WR_DONE <= 1'b0;
      RD_DONE <= 1'b0;
    end else begin
      WR_DONE <= 1'b0;
      RD_DONE <= 1'b0;
      case (state_reg)
        H_IDLE: begin
          if (CMD_VALID) begin
            req_write_reg <= CMD_WRITE;
            req_addr_reg <= CMD_ADDR;
            req_data_reg <= CMD_WDATA;
            req_bw_reg <= CMD_BW_N;
            CMD_READY <= 1'b0;
            state_reg <= H_ARM;
          end
        end
        H_ARM: begin
          if (fall_tick) begin
            ld_n_reg <= 1'b0;
            rnw_reg <= ~req_write_reg;
            addr_reg <= req_addr_reg;
            state_reg <= H_CMD;
          end
        end
        H_CMD: begin
          if (fall_tick) begin
            ld_n_reg <= 1'b1;
            beat_reg <= 3'h0;
            state_reg <= req_write_reg ? H_WR : H_RD;
          end
        end
        H_WR: begin
          if (data_tick) begin
            if (beat_reg == 3'(BURST_LEN)) begin
              oe_reg <= 1'b0;
              bw_n_reg <= BW_N_RST;
              WR_DONE <= 1'b1;
              CMD_READY <= 1'b1;
              state_reg <= H_IDLE;
            end else begin
              oe_reg <= 1'b1;
              dq_reg <= req_data_reg[beat_reg*DATA_W +: DATA_W];
              bw_n_reg <= req_bw_reg[beat_reg*BW_W +: BW_W];
              beat_reg <= beat_reg + 3'h1;
            end
          end
        end
        H_RD: begin
          // Bus stays released until the whole burst is captured
          if (cap_last) begin
            RD_DONE <= 1'b1;
            CMD_READY <= 1'b1;
            state_reg <= H_IDLE;
          end
        end
        default: begin
          state_reg <= H_IDLE;
        end
      endcase
    end
  end

  assign LINK.k = k_reg;
  assign LINK.k_n = kn_reg;
  assign LINK.load_n = ld_n_reg;
  assign LINK.read_not_write = rnw_reg;
  assign LINK.sync_address = addr_reg;
  assign LINK.byte_write_n = bw_n_reg;
  assign LINK.dll_off_n = dll_reg;
  assign LINK.dq_ctrl_out = dq_reg;
  assign LINK.dq_ctrl_oe = oe_reg;
endmodule : dbcsp_ctrl

// >>> dbcsp_link_asserts.sv
`timescale 1ns/1ps
module dbcsp_link_asserts (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic k,
  input wire logic load_n,
  input wire logic read_not_write,
  input wire logic dll_off_n,
  input wire logic echo_clock,
  input wire logic echo_clock_n,
  input wire logic read_valid,
  input wire logic [dbcsp_pkg::DATA_W-1:0] dq_sram_out,
  input wire logic dq_sram_oe,
  input wire logic dq_ctrl_oe
);
  import dbcsp_pkg::*;
  logic [4:0] still_reg;
  logic echo_reg;

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  // ============================================================
  // Stuck echo detector; a dead clock shows no edge to trigger on
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      echo_reg <= 1'b0;
    end else begin
      echo_reg <= echo_clock;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      still_reg <= 5'h00;
    end else if (echo_reg != echo_clock) begin
      still_reg <= 5'h00;
    end else if (still_reg != 5'h1F) begin
      still_reg <= still_reg + 5'h01;
    end
  end

  // ============================================================
  // Link relations
  a_echo_pair: assert property (echo_clock_n == !echo_clock)
    else $error("echo clocks not complementary");
  a_echo_alive: assert property (still_reg < 5'h18)
    else $error("echo clock stopped");
  a_echo_period: assert property ($changed(echo_clock) |->
    ##1 $stable(echo_clock)[*5] ##1 $changed(echo_clock))
    else $error("echo clock half period wrong");
  a_bus_single: assert property (!(dq_sram_oe && dq_ctrl_oe))
    else $error("both ends drive the data bus");
  a_read_dll: assert property ($rose(k) && !load_n && read_not_write
    && dll_off_n |-> ##[32:34] $rose(dq_sram_oe))
    else $error("read latency with loop on wrong");
  a_read_bypass: assert property ($rose(k) && !load_n
    && read_not_write && !dll_off_n |-> ##[14:16] $rose(dq_sram_oe))
    else $error("read latency in bypass wrong");
  a_burst_four: assert property ($rose(dq_sram_oe) |->
    (dq_sram_oe throughout ##23 1'b1) ##1 !dq_sram_oe)
    else $error("read burst length wrong");
  a_valid_lead: assert property ($rose(read_valid) |->
    ##[5:7] $rose(dq_sram_oe))
    else $error("valid does not lead first word");
  a_valid_drop: assert property ($fell(read_valid) |->
    ##[11:13] $fell(dq_sram_oe))
    else $error("valid does not drop before last word");
  a_valid_align: assert property ($changed(read_valid) |->
    $changed(echo_clock))
    else $error("valid moves off echo edge");
  a_data_align: assert property (dq_sram_oe && $changed(dq_sram_out)
    |-> $changed(echo_clock))
    else $error("read data moves off echo edge");
  a_write_quiet: assert property ($rose(k) && !load_n
    && !read_not_write |-> !dq_sram_oe[*8])
    else $error("device drives bus on write");
endmodule : dbcsp_link_asserts

// >>> dbcsp_tb.sv
`timescale 1ns/1ps
module dbcsp_tb;
  import dbcsp_pkg::*;
  logic sys_clk;
  logic rst_n;
  logic cmd_valid;
  logic cmd_write;
  logic [ADDR_W-1:0] cmd_addr;
  logic [BURST_W-1:0] cmd_wdata;
  logic [BURST_BW_W-1:0] cmd_bw_n;
  logic dll_off_n;
  logic cmd_ready;
  logic wr_done;
  logic rd_done;
  logic [BURST_W-1:0] rd_data;
  logic [BURST_W-1:0] rd_data_x18;
  logic dll_locked;
  logic dll_bypassed;
  logic [BURST_W-1:0] pat_a;
  logic [BURST_W-1:0] pat_b;
  int mismatches;
  int tests_run;

  dbcsp_if link ();

  dbcsp_ctrl dbcsp_ctrl_inst (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .LINK(link),
    .CMD_VALID(cmd_valid), .CMD_WRITE(cmd_write), .CMD_ADDR(cmd_addr),
    .CMD_WDATA(cmd_wdata), .CMD_BW_N(cmd_bw_n), .DLL_OFF_N(dll_off_n),
    .CMD_READY(cmd_ready), .WR_DONE(wr_done), .RD_DONE(rd_done),
    .RD_DATA(rd_data)
  );

  dbcsp_sram #(.X36_CFG(1'b1)) dbcsp_sram_inst (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .LINK(link),
    .DLL_LOCKED(dll_locked), .DLL_BYPASSED(dll_bypassed)
  );

  // Narrow pair on its own link, in lockstep on the same commands
  dbcsp_if link_x18 ();

  dbcsp_ctrl dbcsp_ctrl_x18_inst (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .LINK(link_x18),
    .CMD_VALID(cmd_valid), .CMD_WRITE(cmd_write), .CMD_ADDR(cmd_addr),
    .CMD_WDATA(cmd_wdata), .CMD_BW_N(cmd_bw_n), .DLL_OFF_N(dll_off_n),
    .CMD_READY(), .WR_DONE(), .RD_DONE(), .RD_DATA(rd_data_x18)
  );

  dbcsp_sram #(.X36_CFG(1'b0)) dbcsp_sram_x18_inst (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .LINK(link_x18),
    .DLL_LOCKED(), .DLL_BYPASSED()
  );

  dbcsp_link_asserts dbcsp_link_asserts_inst (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .k(link.k), .load_n(link.load_n),
    .read_not_write(link.read_not_write), .dll_off_n(link.dll_off_n),
    .echo_clock(link.echo_clock), .echo_clock_n(link.echo_clock_n),
    .read_valid(link.read_valid), .dq_sram_out(link.dq_sram_out),
    .dq_sram_oe(link.dq_sram_oe), .dq_ctrl_oe(link.dq_ctrl_oe)
  );

  always #5 sys_clk = ~sys_clk;

  // ============================================================
  // Reporting
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [BURST_W-1:0] seen,
                       input logic [BURST_W-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // ============================================================
  // Expected burst after a masked write over old contents
  function automatic logic [BURST_W-1:0] merge(
    input logic [BURST_W-1:0] old_d, input logic [BURST_W-1:0] new_d,
    input logic [BURST_BW_W-1:0] bw);
    logic [BURST_W-1:0] r;
    r = old_d;
    for (int i = 0; i < BURST_BW_W; i++) begin
      if (!bw[i]) begin
        r[LANE_W*i +: LANE_W] = new_d[LANE_W*i +: LANE_W];
      end
    end
    return r;
  endfunction : merge

  // Narrow part keeps lanes 0 and 1 of each beat, the rest reads zero
  function automatic logic [BURST_W-1:0] narrow(input logic [BURST_W-1:0] d);
    return merge('0, d, 16'hCCCC);
  endfunction : narrow

  // ============================================================
  // One burst through the user port, waiting for its done pulse
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [BURST_W-1:0] d,
                        input logic [BURST_BW_W-1:0] bw);
    int n;
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_bw_n <= bw;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    for (n = 0; n < 4000; n++) begin
      @(negedge sys_clk);
      if (wr_done === 1'b1 || rd_done === 1'b1) break;
    end
    if (n == 4000) begin
      mismatches++;
      summarize();
    end
    // Hand back on a rising edge so callers drive there
    @(posedge sys_clk);
  endtask : access

  // Lock takes thousands of link cycles, so the bound is generous
  task automatic wait_lock();
    int n;
    for (n = 0; n < 30000; n++) begin
      @(negedge sys_clk);
      if (dll_locked === 1'b1) break;
    end
    if (n == 30000) begin
      mismatches++;
      summarize();
    end
    @(posedge sys_clk);
  endtask : wait_lock

  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = '0;
    cmd_wdata = '0;
    cmd_bw_n = 16'hFFFF;
    dll_off_n = 1'b1;
    mismatches = 0;
    tests_run = 0;
    pat_a = {36'h3_0000_0003, 36'h2_0000_0002, 36'h1_0000_0001,
             36'h0_ABCD_EF00};
    pat_b = ~pat_a;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    access(1'b1, 19'h00005, pat_a, 16'h0000);
    access(1'b0, 19'h00005, '0, 16'hFFFF);
    check("full burst", rd_data, pat_a);
    check("narrow full", rd_data_x18, narrow(pat_a));
    check("ready after burst", cmd_ready, 1'b1);
    access(1'b1, 19'h00005, pat_b, 16'hA5C3);
    access(1'b1, 19'h7FFFF, pat_b, 16'h0000);
    access(1'b0, 19'h00005, '0, 16'hFFFF);
    check("masked lanes", rd_data, merge(pat_a, pat_b, 16'hA5C3));
    check("narrow masked", rd_data_x18,
          narrow(merge(pat_a, pat_b, 16'hA5C3)));
    access(1'b0, 19'h7FFFF, '0, 16'hFFFF);
    check("top address", rd_data, pat_b);
    check("narrow top", rd_data_x18, narrow(pat_b));
    wait_lock();
    check("lock after time", dll_locked, 1'b1);
    dll_off_n <= 1'b0;
    repeat (100) @(posedge sys_clk);
    check("bypass flag", dll_bypassed, 1'b1);
    check("lock cleared", dll_locked, 1'b0);
    access(1'b0, 19'h00005, '0, 16'hFFFF);
    check("bypass read", rd_data, merge(pat_a, pat_b, 16'hA5C3));
    dll_off_n <= 1'b1;
    repeat (1000) @(posedge sys_clk);
    check("lock not early", dll_locked, 1'b0);
    wait_lock();
    check("relock", dll_locked, 1'b1);
    summarize();
  end
endmodule : dbcsp_tb
